// ### include/tmt_pkg.sv
package tmt_pkg;
  localparam logic [11:0] CONTROL_OFS  = 12'h0c8;
  localparam logic [11:0] MODE_OFS     = 12'h0c9;
  localparam logic [11:0] CAPLOW_OFS   = 12'h0ca;
  localparam logic [11:0] CAPHIGH_OFS  = 12'h0cb;
  localparam logic [11:0] CNTLOW_OFS   = 12'h0cc;
  localparam logic [11:0] CNTHIGH_OFS  = 12'h0cd;
  localparam logic [7:0]  CONTROL_RST  = 8'h00;
  localparam logic [7:0]  MODE_RST     = 8'h00;
  localparam logic [7:0]  MODE_UNUSED  = 8'hfc;
  localparam logic [15:0] COUNT_MAX    = 16'hffff;
  localparam logic [15:0] COUNT_RST    = 16'h0000;
  localparam int          OVF_BIT      = 7;
  localparam int          EXT_BIT      = 6;
  localparam int          RXB_BIT      = 5;
  localparam int          TXB_BIT      = 4;
  localparam int          TEN_BIT      = 3;
  localparam int          RUN_BIT      = 2;
  localparam int          SRC_BIT      = 1;
  localparam int          CAP_BIT      = 0;
  localparam int          OE_BIT       = 1;
  localparam int          DOWN_COUNT_ENABLE_BIT     = 0;
endpackage

// ### src/tmt_edge_det.sv
`timescale 1ns/10ps
module tmt_edge_det (
  input  wire logic ref_clk,
  input  wire logic nrst,
  input  wire logic pinIn,
  output logic      pinLevel,
  output logic      fallPulse
);
  logic smp_r;
  // previous sample compared to current; pins are already synchronous
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      smp_r <= 1'b1;
    end else begin
      smp_r <= pinIn;
    end
  end
  assign pinLevel  = pinIn;
  assign fallPulse = smp_r & ~pinIn;
endmodule

// ### src/tmt_timer_two.sv
`timescale 1ns/10ps
module tmt_timer_two (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        triggerPin,
  input  wire logic        countPinIn,
  output logic             countPinOut,
  output logic             countPinOe,
  output logic             timerIrq,
  output logic             rxBaudTick,
  output logic             txBaudTick,
  output logic             rxBaudSelect,
  output logic             txBaudSelect
);
  import tmt_pkg::*;

  logic [7:0]  ctrl_r;
  logic [1:0]  mode_r;
  logic [15:0] count_r;
  logic [15:0] cap_r;
  logic        half_r;
  logic        clkOut_r;
  logic        edgeIrq_r;
  logic        rxTick_r;
  logic        txTick_r;

  logic trigLevel;
  logic trigFall;
  logic cntFall;

  tmt_edge_det trigDet (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .pinIn     (triggerPin),
    .pinLevel  (trigLevel),
    .fallPulse (trigFall)
  );

  tmt_edge_det cntDet (
    .ref_clk   (ref_clk),
    .nrst      (nrst),
    .pinIn     (countPinIn),
    .pinLevel  (),
    .fallPulse (cntFall)
  );

  // one register per aligned word; the byte address is four times the index
  function automatic logic [11:0] byteAddr(input logic [11:0] idx);
    return {idx[9:0], 2'b00};
  endfunction

  // apb decode: zero wait states, every access completes in its access cycle
  // an unaligned address matches no register, so it reads zero and flags an error
  wire         acc       = psel & penable;
  wire         wr        = acc & pwrite;
  wire [9:0]   regIdx    = paddr[11:2];
  wire         aligned   = (paddr[1:0] == 2'b00);
  wire         mapped    = aligned && (regIdx >= CONTROL_OFS[9:0]) && (regIdx <= CNTHIGH_OFS[9:0]);
  wire         wrCtrl    = wr && (paddr == byteAddr(CONTROL_OFS));
  wire         wrMode    = wr && (paddr == byteAddr(MODE_OFS));
  wire         wrCapLo   = wr && (paddr == byteAddr(CAPLOW_OFS));
  wire         wrCapHi   = wr && (paddr == byteAddr(CAPHIGH_OFS));
  wire         wrCntLo   = wr && (paddr == byteAddr(CNTLOW_OFS));
  wire         wrCntHi   = wr && (paddr == byteAddr(CNTHIGH_OFS));
  wire [7:0]   wByte     = pwdata[7:0];

  wire         rxBaud    = ctrl_r[RXB_BIT];
  wire         txBaud    = ctrl_r[TXB_BIT];
  wire         baudMode  = rxBaud | txBaud;
  wire         trigEn    = ctrl_r[TEN_BIT];
  wire         run       = ctrl_r[RUN_BIT];
  wire         srcPin    = ctrl_r[SRC_BIT];
  wire         capMode   = ctrl_r[CAP_BIT];
  wire         outEn     = mode_r[OE_BIT];
  wire         downEn    = mode_r[DOWN_COUNT_ENABLE_BIT];
  wire         clkOutMode = outEn & ~srcPin;
  wire         fastMode  = baudMode | clkOutMode;
  // reload with down count: direction follows the trigger pin
  wire         dcMode    = ~capMode & downEn & ~baudMode;
  wire         goDown    = dcMode & ~trigLevel;

  // every-two-clocks tick in baud and clock-out modes, else source select
  wire         tick      = run & (fastMode ? half_r
                                           : (srcPin ? cntFall : 1'b1));
  wire         upRoll    = tick & ~goDown & (count_r == COUNT_MAX);
  wire         downHit   = tick & goDown & (count_r == cap_r);
  wire         rollEvt   = upRoll | downHit;
  wire         trigAct   = trigFall & trigEn & ~baudMode;
  wire         doCapture = trigAct & capMode;
  wire         trigReload = trigAct & ~capMode & ~downEn;
  wire         doReload  = (upRoll & (~capMode | baudMode)) | trigReload;
  wire         setOvf    = rollEvt & ~baudMode & ~clkOutMode;
  wire         setExtEdge = trigFall & trigEn & ~(~capMode & downEn);
  wire         togExt    = dcMode & rollEvt;

  wire [15:0]  downNext  = (count_r == cap_r) ? COUNT_MAX : count_r - 16'h0001;
  wire [15:0]  stepNext  = goDown ? downNext : count_r + 16'h0001;

  wire [7:0]   modeRead  = MODE_UNUSED | {6'h00, mode_r};

  // software write first, hardware set wins over a software clear
  wire [7:0]   ctrlWr    = wrCtrl ? wByte : ctrl_r;
  wire         ovfNxt    = setOvf | ctrlWr[OVF_BIT];
  wire         extNxt    = togExt ? ~ctrl_r[EXT_BIT] : (setExtEdge | ctrlWr[EXT_BIT]);

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= CONTROL_RST;
      mode_r <= MODE_RST[1:0];
    end else begin
      ctrl_r <= {ovfNxt, extNxt, ctrlWr[5:0]};
      if (wrMode) begin
        mode_r <= wByte[1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      count_r <= COUNT_RST;
    end else if (wrCntLo) begin
      count_r <= {count_r[15:8], wByte};
    end else if (wrCntHi) begin
      count_r <= {wByte, count_r[7:0]};
    end else if (doReload) begin
      count_r <= cap_r;
    end else if (tick) begin
      count_r <= stepNext;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cap_r <= COUNT_RST;
    end else if (doCapture) begin
      cap_r <= count_r;
    end else if (wrCapLo) begin
      cap_r <= {cap_r[15:8], wByte};
    end else if (wrCapHi) begin
      cap_r <= {wByte, cap_r[7:0]};
    end
  end

  // half-rate divider; clock output flips on each up-count rollover, not when a down count hits the capture value
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      half_r   <= 1'b0;
      clkOut_r <= 1'b0;
    end else begin
      half_r <= fastMode ? ~half_r : 1'b0;
      if (!clkOutMode) begin
        clkOut_r <= 1'b0;
      end else if (upRoll) begin
        clkOut_r <= ~clkOut_r;
      end
    end
  end

  // interrupt request held until flag cleared; toggle mode never requests on the edge flag
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      edgeIrq_r <= 1'b0;
      rxTick_r  <= 1'b0;
      txTick_r  <= 1'b0;
    end else begin
      edgeIrq_r <= extNxt & ~dcMode;
      rxTick_r  <= upRoll & rxBaud;
      txTick_r  <= upRoll & txBaud;
    end
  end

  logic [7:0] rdByte;
  always_comb begin
    case (paddr)
      byteAddr(CONTROL_OFS): rdByte = ctrl_r;
      byteAddr(MODE_OFS):    rdByte = modeRead;
      byteAddr(CAPLOW_OFS):  rdByte = cap_r[7:0];
      byteAddr(CAPHIGH_OFS): rdByte = cap_r[15:8];
      byteAddr(CNTLOW_OFS):  rdByte = count_r[7:0];
      byteAddr(CNTHIGH_OFS): rdByte = count_r[15:8];
      default:               rdByte = 8'h00;
    endcase
  end

  // read data registered during setup so it is a flop output in access phase
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= {24'h000000, rdByte};
    end
  end

  assign pready       = 1'b1;
  assign pslverr      = acc & ~mapped;
  assign timerIrq     = (ctrl_r[OVF_BIT] & ~clkOutMode) | edgeIrq_r;
  assign countPinOut  = clkOut_r;
  assign countPinOe   = clkOutMode;
  assign rxBaudTick   = rxTick_r;
  assign txBaudTick   = txTick_r;
  assign rxBaudSelect = rxBaud;
  assign txBaudSelect = txBaud;
endmodule

// ### bench/tmt_pins_model.sv
`timescale 1ns/10ps
module tmt_pins_model (
  input  wire logic ref_clk,
  input  wire logic trigLow,
  input  wire logic cntPulse,
  input  wire logic countPinOut,
  input  wire logic countPinOe,
  output logic      triggerPin,
  output logic      countPinIn
);
  logic pinDrv_r;
  // levels stay a whole cycle so a synchronous sampler never misses an edge
  always_ff @(posedge ref_clk) begin
    triggerPin <= !trigLow;
    pinDrv_r   <= !cntPulse;
  end
  // the design's clock output owns the wire while enabled
  assign countPinIn = countPinOe ? countPinOut : pinDrv_r;
endmodule

// ### bench/tmt_chk.sv
`timescale 1ns/10ps
module tmt_chk import tmt_pkg::*; (
  input wire logic        ref_clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        countPinOut,
  input wire logic        countPinOe,
  input wire logic        timerIrq,
  input wire logic        rxBaudTick,
  input wire logic        rxBaudSelect,
  input wire logic        txBaudSelect
);
  localparam logic [11:0] CTRL_ADDR = {CONTROL_OFS[9:0], 2'b00};
  localparam logic [11:0] MODE_ADDR = {MODE_OFS[9:0], 2'b00};
  logic down_count_enable_r;
  wire acc = psel && penable;
  wire wrCtl = acc && pwrite && paddr == CTRL_ADDR;
  // shadow of the down-count bit, needed to know when the flag may not interrupt
  always_ff @(posedge ref_clk or negedge nrst)
    if (!nrst) down_count_enable_r <= 1'b0;
    else if (acc && pwrite && paddr == MODE_ADDR) down_count_enable_r <= pwdata[0];
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence sExtSet; wrCtl && pwdata[6] && !(down_count_enable_r && !pwdata[0]); endsequence
  sequence sExtQuiet; wrCtl && pwdata[7:6] == 2'b01 && !pwdata[2] && down_count_enable_r && !pwdata[0]; endsequence
  mode_ones_a: assert property (acc && !pwrite && paddr == MODE_ADDR |-> prdata[7:2] == 6'h3f)
    else $error("mode upper bits");
  sel_mirror_a: assert property (wrCtl |=> rxBaudSelect == $past(pwdata[5]) && txBaudSelect == $past(pwdata[4]))
    else $error("baud select");
  rx_tick_a: assert property (rxBaudTick |-> $past(rxBaudSelect))
    else $error("tick without select");
  tick_space_a: assert property (rxBaudTick |=> !rxBaudTick)
    else $error("tick spacing");
  clk_out_a: assert property (countPinOe && $changed(countPinOut) |=> $stable(countPinOut))
    else $error("clock out rate");
  ext_irq_a: assert property (sExtSet |=> timerIrq)
    else $error("flag irq");
  quiet_irq_a: assert property (sExtQuiet |=> !timerIrq)
    else $error("toggle flag irq");
  bad_addr_a: assert property (acc && (paddr[1:0] != 2'b00 || paddr[11:2] < CONTROL_OFS[9:0]
                                       || paddr[11:2] > CNTHIGH_OFS[9:0]) |-> pslverr && prdata == 32'h0)
    else $error("unmapped");
  ready_a: assert property (pready) else $error("ready low");
endmodule
bind tmt_timer_two tmt_chk i_tmt_chk (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .countPinOut(countPinOut), .countPinOe(countPinOe), .timerIrq(timerIrq), .rxBaudTick(rxBaudTick),
  .rxBaudSelect(rxBaudSelect), .txBaudSelect(txBaudSelect));

// ### bench/timer_two_capture_reload_tb_top.sv
`timescale 1ns/10ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin miscompares++; $display("wrong value %0t %h %h", $time, a, b); end end
module timer_two_capture_reload_tb_top;
  import tmt_pkg::*;
  logic ref_clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, trigLow = 0, cntPulse = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  wire [31:0] prdata;
  wire pready, pslverr, triggerPin, countPinIn, countPinOut, countPinOe, timerIrq, rxBaudTick, txBaudTick;
  int miscompares = 0, nTests = 0, cyc = 0, ticks, txTicks, tog, n;
  logic lastOut;
  logic [7:0] st, expRd, expQ[$];
  tmt_timer_two i_tmt_timer_two (.ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .triggerPin(triggerPin),
    .countPinIn(countPinIn), .countPinOut(countPinOut), .countPinOe(countPinOe), .timerIrq(timerIrq),
    .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick), .rxBaudSelect(), .txBaudSelect());
  tmt_pins_model i_tmt_pins_model (.ref_clk(ref_clk), .trigLow(trigLow), .cntPulse(cntPulse),
    .countPinOut(countPinOut), .countPinOe(countPinOe), .triggerPin(triggerPin), .countPinIn(countPinIn));
  initial forever #50 ref_clk = ~ref_clk;
  task automatic finish_test();
    $display("checks %0d miscompares %0d", nTests, miscompares);
    if (miscompares == 0 && nTests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      finish_test();
    end
  end
  // read data is taken only at the access edge; pop once so a mismatch report cannot eat a second note
  always @(posedge ref_clk) if (psel && penable && !pwrite && pready === 1'b1) begin
    expRd = expQ.pop_front();
    `CHK(prdata[7:0], expRd)
  end
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    // a register index becomes an aligned word address
    psel <= 1; pwrite <= w; paddr <= {a[9:0], 2'b00}; pwdata <= {24'h0, d};
    @(posedge ref_clk) penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 0; penable <= 0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d); xfer(1, a, d); endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e); expQ.push_back(e); xfer(0, a, 8'h00); endtask
  task automatic pulses(input int k);
    repeat (k) begin cntPulse <= 1; @(posedge ref_clk) cntPulse <= 0; repeat (2) @(posedge ref_clk); end
  endtask
  task automatic trig(); trigLow <= 1; repeat (3) @(posedge ref_clk); trigLow <= 0; repeat (3) @(posedge ref_clk); endtask
  initial begin
    void'($urandom(32'h1e09a3ff));
    repeat (16) @(posedge ref_clk);
    nrst <= 1;
    @(posedge ref_clk);
    rd(CONTROL_OFS, CONTROL_RST); rd(MODE_OFS, MODE_UNUSED | MODE_RST); rd(12'h0d0, 8'h00);
    n = 1 + $urandom % 8; st = 8'($urandom % 240); trigLow <= 1;
    wr(CNTLOW_OFS, st); wr(CONTROL_OFS, 8'h06); pulses(n); wr(CONTROL_OFS, 8'h02); pulses(2);
    rd(CNTLOW_OFS, st + 8'(n));
    trigLow <= 0;
    wr(CNTHIGH_OFS, 8'h12); wr(CNTLOW_OFS, 8'h34); wr(CONTROL_OFS, 8'h09); trig();
    rd(CAPLOW_OFS, 8'h34); rd(CAPHIGH_OFS, 8'h12); rd(CONTROL_OFS, 8'h49);
    `CHK(timerIrq, 1'b1)
    wr(CONTROL_OFS, 8'h01); trig(); rd(CONTROL_OFS, 8'h01);
    wr(CONTROL_OFS, 8'h04); repeat (10) @(posedge ref_clk); wr(CONTROL_OFS, 8'h08);
    rd(CNTLOW_OFS, 8'h41); rd(CNTHIGH_OFS, 8'h12);
    trig(); rd(CNTLOW_OFS, 8'h34); rd(CONTROL_OFS, 8'h48);
    wr(CONTROL_OFS, 8'h28); wr(CNTLOW_OFS, 8'h00); trig(); rd(CNTLOW_OFS, 8'h00); rd(CONTROL_OFS, 8'h68);
    wr(CAPHIGH_OFS, 8'h10); wr(CAPLOW_OFS, 8'h00); wr(CNTHIGH_OFS, 8'hff); wr(CNTLOW_OFS, 8'hfe);
    wr(CONTROL_OFS, 8'h06); pulses(2);
    rd(CONTROL_OFS, 8'h86); rd(CNTHIGH_OFS, 8'h10); rd(CNTLOW_OFS, 8'h00);
    wr(CONTROL_OFS, 8'h02); wr(MODE_OFS, 8'h01); trigLow <= 1;
    wr(CAPHIGH_OFS, 8'h00); wr(CAPLOW_OFS, 8'h10); wr(CNTHIGH_OFS, 8'h00); wr(CNTLOW_OFS, 8'h11);
    wr(CONTROL_OFS, 8'h06); pulses(2);
    rd(CNTHIGH_OFS, 8'hff); rd(CNTLOW_OFS, 8'hff); rd(CONTROL_OFS, 8'hc6);
    trigLow <= 0; pulses(1); rd(CNTLOW_OFS, 8'h10); rd(CONTROL_OFS, 8'h86);
    wr(CONTROL_OFS, 8'h40); `CHK(timerIrq, 1'b0)
    trigLow <= 0; wr(MODE_OFS, 8'h00); wr(CNTHIGH_OFS, 8'hff); wr(CNTLOW_OFS, 8'hff);
    wr(CAPHIGH_OFS, 8'hff); wr(CAPLOW_OFS, 8'hfe); wr(CONTROL_OFS, 8'h36); ticks = 0; txTicks = 0;
    repeat (40) @(posedge ref_clk) begin ticks += rxBaudTick; txTicks += txBaudTick; end
    wr(CONTROL_OFS, 8'h32); rd(CONTROL_OFS, 8'h32);
    `CHK(ticks >= 9 && ticks <= 11, 1'b1)
    `CHK(txTicks >= 9 && txTicks <= 11, 1'b1)
    wr(CONTROL_OFS, 8'h00); wr(MODE_OFS, 8'h02); wr(CAPLOW_OFS, 8'hff); wr(CONTROL_OFS, 8'h04);
    lastOut = countPinOut; tog = 0;
    repeat (20) @(posedge ref_clk) begin tog += (countPinOut !== lastOut); lastOut = countPinOut; end
    `CHK(countPinOe, 1'b1)
    `CHK(tog >= 9 && tog <= 10, 1'b1)
    rd(CONTROL_OFS, 8'h04); wr(CONTROL_OFS, 8'h44); `CHK(timerIrq, 1'b1)
    finish_test();
  end
endmodule
